//--- core/mfs_cfg.svh
// Address map, field positions, reset values and timing of the status bank
`ifndef MFS_CFG_SVH
`define MFS_CFG_SVH
// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define MFS_ADDR_FAULT       5'h00
`define MFS_ADDR_DIAG1       5'h01
`define MFS_ADDR_DIAG2       5'h02
`define MFS_ADDR_CTRL_FIRST  5'h03
`define MFS_ADDR_CONTROL_FOUR       5'h06
`define MFS_ADDR_CTRL_LAST   5'h09
`define MFS_CTRL_COUNT       7
// ----------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------
`define MFS_CLR_BIT          7
`define MFS_CLR_MASK         8'h7f
`define MFS_STATUS_RESET     8'h00
`define MFS_CTRL_RESET       8'h00
`define MFS_CONTROL_TWO_RESET      8'h0f
// ----------------------------------------------------------------------
// Serial frame
// ----------------------------------------------------------------------
`define MFS_FRAME_BITS       6'h10
`define MFS_ADDR_READY_BITS  6'h08
`define MFS_CNT_MAX          6'h3f
`define MFS_READ_BIT         14
`define MFS_ADDR_HI          13
`define MFS_ADDR_LO          9
// ----------------------------------------------------------------------
// Synchronisers and timing
// ----------------------------------------------------------------------
`define MFS_NCOND            17
`define MFS_NSYNC            22
`define MFS_SYNC_RESET       22'h320000
`define MFS_CLK_PERIOD_NS    5
`define MFS_IDLE_TIMEOUT_NS  10000
`define MFS_IDLE_CYCLES \
   ((`MFS_IDLE_TIMEOUT_NS + `MFS_CLK_PERIOD_NS - 1) / `MFS_CLK_PERIOD_NS)
`define MFS_IDLE_W           12
`endif

//--- core/mfs_pkg.sv
// Types shared by the fault status bank
package mfs_pkg;
`include "mfs_cfg.svh"
   typedef logic [7:0]            mfs_byte_t;
   typedef logic [15:0]           mfs_frame_t;
   typedef logic [4:0]            mfs_addr_t;
   typedef logic [`MFS_NCOND-1:0] mfs_cond_t;
   typedef enum {MFS_IDLE, MFS_ACTIVE} mfs_state_t;
endpackage

//--- core/mfs_spi_if.sv
// Carrier between the serial shifter and the register bank
`timescale 1ns/10ps
interface mfs_spi_if;
   import mfs_pkg::*;
   logic       frame_done;
   mfs_frame_t frame;
   logic       proto_err;
   mfs_addr_t  addr;
   mfs_byte_t  rdata;
   mfs_byte_t  status;
   modport shifter (output frame_done, frame, proto_err, addr,
                    input rdata, status);
   modport regs    (input frame_done, frame, proto_err, addr,
                    output rdata, status);
endinterface

//--- core/mfs_spi_shifter.sv
// Serial frame shifter with protocol error detection
`timescale 1ns/10ps
`include "mfs_cfg.svh"
module mfs_spi_shifter
   import mfs_pkg::*;
(
   // Clock and reset
   input  wire logic clock,
   input  wire logic arst_n,
   // Synchronised pins
   input  wire logic cs_n_s,
   input  wire logic sclk_s,
   input  wire logic sdi_s,
   output logic      sdo,
   // Register side
   mfs_spi_if.shifter lnk
);
   import mfs_pkg::*;
   localparam int IDLE_LAST = `MFS_IDLE_CYCLES - 1;

   mfs_state_t          state;
   logic                sclk_d;
   logic                cs_d;
   logic [5:0]          bit_cnt;
   logic [`MFS_IDLE_W-1:0] idle_cnt;
   mfs_frame_t          rx;
   mfs_frame_t          tx;
   logic                load_pend;
   logic                rise;
   logic                fall;
   logic                cs_start;
   logic                cs_end;
   logic                idle_hit;

   assign rise     = sclk_s & ~sclk_d;
   assign fall     = ~sclk_s & sclk_d;
   assign cs_start = cs_d & ~cs_n_s;
   assign cs_end   = ~cs_d & cs_n_s;
   assign idle_hit = (state == MFS_ACTIVE) && (bit_cnt == 6'h00)
                     && (idle_cnt == `MFS_IDLE_W'(IDLE_LAST)) && !rise;
   assign lnk.addr = rx[5:1];
   assign sdo      = tx[15];

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sclk_d <= 1'b0;
         cs_d   <= 1'b1;
      end
      else
      begin
         sclk_d <= sclk_s;
         cs_d   <= cs_n_s;
      end
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         state <= MFS_IDLE;
      else
         case (state)
            MFS_IDLE:   if (cs_start) state <= MFS_ACTIVE;
            MFS_ACTIVE: if (cs_end) state <= MFS_IDLE;
            default:    state <= MFS_IDLE;
         endcase
   end

   // Counts past sixteen so overlong frames stay visible
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         bit_cnt  <= 6'h00;
         idle_cnt <= '0;
         rx       <= '0;
      end
      else if (cs_start)
      begin
         bit_cnt  <= 6'h00;
         idle_cnt <= '0;
      end
      else if (state == MFS_ACTIVE)
      begin
         if (rise)
         begin
            rx <= {rx[14:0], sdi_s};
            if (bit_cnt != `MFS_CNT_MAX)
               bit_cnt <= bit_cnt + 6'h01;
         end
         if (bit_cnt == 6'h00 && idle_cnt != `MFS_IDLE_W'(IDLE_LAST) + 1'b1)
            idle_cnt <= idle_cnt + 1'b1;
      end
   end

   // Reply: status byte, then the addressed register
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tx        <= '0;
         load_pend <= 1'b0;
      end
      else
      begin
         load_pend <= rise && (state == MFS_ACTIVE)
                      && (bit_cnt == `MFS_ADDR_READY_BITS - 6'h01);
         if (cs_start)
            tx <= {lnk.status, 8'h00};
         else if (load_pend)
            tx <= {tx[15], lnk.rdata, 7'h00};
         else if (fall && state == MFS_ACTIVE)
            tx <= {tx[14:0], 1'b0};
      end
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         lnk.frame_done <= 1'b0;
         lnk.proto_err  <= 1'b0;
         lnk.frame      <= '0;
      end
      else
      begin
         lnk.frame_done <= cs_end && (state == MFS_ACTIVE)
                           && (bit_cnt == `MFS_FRAME_BITS);
         lnk.proto_err  <= idle_hit || (cs_end && (state == MFS_ACTIVE)
                           && (bit_cnt > `MFS_FRAME_BITS));
         if (cs_end)
            lnk.frame <= rx;
      end
   end

   property p_idle_error;
      @(posedge clock) disable iff (!arst_n)
      idle_hit |=> lnk.proto_err;
   endproperty
   a_idle_error: assert property (p_idle_error)
      else $error("silent select not flagged");

   property p_long_frame;
      @(posedge clock) disable iff (!arst_n)
      (cs_end && state == MFS_ACTIVE
       && bit_cnt == `MFS_FRAME_BITS + 6'h01) |=> lnk.proto_err;
   endproperty
   a_long_frame: assert property (p_long_frame)
      else $error("overlong frame not flagged");
endmodule

//--- core/mfs_status_regs.sv
// Fault and diagnostic status bank with serial register access
// Function
// - fault bit is inverse of fault pin
// - overlong frame or idle select flags error
// - protocol error drives fault pin low
// - error clears on clear command once gone
// - undervoltage flags at bits five, four
// - overcurrent, stall, open load summary bits
// - temperature bit ORs three thermal flags
// - per transistor overcurrent detail register
// - learn done bit four, stall three
// - open load per bridge, bits one, zero
// - seven control registers at three to nine
`timescale 1ns/10ps
`include "mfs_cfg.svh"
module mfs_status_regs
   import mfs_pkg::*;
(
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       arst_n,
   // Serial port
   input  wire logic       chip_select_n,
   input  wire logic       serial_clk,
   input  wire logic       serial_in,
   output logic            serial_out,
   output logic            serial_out_oe,
   // Sleep pin, low pulse clears faults
   input  wire logic       sleep_in_n,
   // Open-drain fault pin
   input  wire logic       fault_out_n_i,
   output logic            fault_out_n_o,
   output logic            fault_out_n_oe,
   // Fault conditions from the power stage
   input  wire logic       supply_undervolt_flag,
   input  wire logic       pump_undervolt_flag,
   input  wire logic       stall_summary_flag,
   input  wire logic       stall_learn_done,
   input  wire logic       under_temp_warning,
   input  wire logic       over_temp_warning,
   input  wire logic       over_temp_shutdown,
   input  wire logic       open_load_bridge_a,
   input  wire logic       open_load_bridge_b,
   input  wire logic       oc_low2_bridge_b,
   input  wire logic       oc_high2_bridge_b,
   input  wire logic       oc_low1_bridge_b,
   input  wire logic       oc_high1_bridge_b,
   input  wire logic       oc_low2_bridge_a,
   input  wire logic       oc_high2_bridge_a,
   input  wire logic       oc_low1_bridge_a,
   input  wire logic       oc_high1_bridge_a,
   // Control register contents
   output mfs_pkg::mfs_byte_t control_one,
   output mfs_pkg::mfs_byte_t control_two,
   output mfs_pkg::mfs_byte_t control_three,
   output mfs_pkg::mfs_byte_t control_four,
   output mfs_pkg::mfs_byte_t control_five,
   output mfs_pkg::mfs_byte_t stall_threshold_ctl,
   output mfs_pkg::mfs_byte_t torque_count_ctl
);
   import mfs_pkg::*;

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   mfs_spi_if lnk ();

   logic [`MFS_NSYNC-1:0] sync_raw;
   logic [`MFS_NSYNC-1:0] sync1;
   logic [`MFS_NSYNC-1:0] sync2;
   localparam logic [`MFS_NSYNC-1:0] SYNC_RST = `MFS_SYNC_RESET;

   mfs_cond_t  cond_raw;
   mfs_cond_t  cond_s;
   mfs_cond_t  latched;
   logic       pin_s, sleep_s, sleep_d;
   logic       sdi_s, sclk_s, cs_s;

   logic [7:0] oc_lat;
   logic       ola_lat, olb_lat, ots_lat, otw_lat, utw_lat;
   logic       lrn_lat, stl_lat, pump_undervolt_flag_lat, supply_undervolt_flag_lat;

   logic       spi_err;
   logic       clr_cmd;
   logic       fault_drive;
   logic       wr_ctrl;
   logic       rd_frame;
   mfs_addr_t  wr_addr;
   mfs_byte_t  wr_data;
   logic [2:0] ctrl_idx;
   mfs_byte_t  ctrl [`MFS_CTRL_COUNT];

   mfs_byte_t  fault_summary;
   mfs_byte_t  overcurrent_detail;
   mfs_byte_t  thermal_stall_openload_detail;
   mfs_byte_t  next_rdata;

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   assign cond_raw = {oc_low2_bridge_b, oc_high2_bridge_b,
                      oc_low1_bridge_b, oc_high1_bridge_b,
                      oc_low2_bridge_a, oc_high2_bridge_a,
                      oc_low1_bridge_a, oc_high1_bridge_a,
                      open_load_bridge_b, open_load_bridge_a,
                      over_temp_shutdown, over_temp_warning,
                      under_temp_warning, stall_learn_done,
                      stall_summary_flag, pump_undervolt_flag,
                      supply_undervolt_flag};
   assign sync_raw = {fault_out_n_i, sleep_in_n, serial_in, serial_clk,
                      chip_select_n, cond_raw};
   assign {pin_s, sleep_s, sdi_s, sclk_s, cs_s, cond_s} = sync2;

   // Idle levels at reset keep pins from faking edges
   genvar gs;
   generate
      for (gs = 0; gs < `MFS_NSYNC; gs++)
      begin : g_sync
         always_ff @(posedge clock or negedge arst_n)
         begin
            if (!arst_n)
            begin
               sync1[gs] <= SYNC_RST[gs];
               sync2[gs] <= SYNC_RST[gs];
            end
            else
            begin
               sync1[gs] <= sync_raw[gs];
               sync2[gs] <= sync1[gs];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Serial shifter
   // ----------------------------------------------------------------------
   mfs_spi_shifter u_shifter (
      .clock  (clock),
      .arst_n (arst_n),
      .cs_n_s (cs_s),
      .sclk_s (sclk_s),
      .sdi_s  (sdi_s),
      .sdo    (serial_out),
      .lnk    (lnk.shifter)
   );

   assign serial_out_oe = ~cs_s;

   // ----------------------------------------------------------------------
   // Frame decode
   // ----------------------------------------------------------------------
   assign rd_frame = lnk.frame[`MFS_READ_BIT];
   assign wr_addr  = lnk.frame[`MFS_ADDR_HI:`MFS_ADDR_LO];
   assign wr_data  = lnk.frame[7:0];
   // status addresses never decode as writes
   assign wr_ctrl  = lnk.frame_done && !rd_frame
                     && wr_addr >= `MFS_ADDR_CTRL_FIRST
                     && wr_addr <= `MFS_ADDR_CTRL_LAST;
   assign ctrl_idx = 3'(wr_addr - `MFS_ADDR_CTRL_FIRST);

   // ----------------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------------
   // one register per address
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         for (int i = 0; i < `MFS_CTRL_COUNT; i++)
            ctrl[i] <= `MFS_CTRL_RESET;
         ctrl[1] <= `MFS_CONTROL_TWO_RESET;
      end
      else if (wr_ctrl)
      begin
         // Clear bit is a command, never stored
         if (wr_addr == `MFS_ADDR_CONTROL_FOUR)
            ctrl[ctrl_idx] <= wr_data & `MFS_CLR_MASK;
         else
            ctrl[ctrl_idx] <= wr_data;
      end
   end

   assign {control_one, control_two, control_three, control_four,
           control_five, stall_threshold_ctl, torque_count_ctl} =
          {ctrl[0], ctrl[1], ctrl[2], ctrl[3], ctrl[4], ctrl[5], ctrl[6]};

   // ----------------------------------------------------------------------
   // Clear command
   // ----------------------------------------------------------------------
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         sleep_d <= 1'b1;
      else
         sleep_d <= sleep_s;
   end

   // clear bit write or sleep pulse end
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         clr_cmd <= 1'b0;
      else
         clr_cmd <= (wr_ctrl && wr_addr == `MFS_ADDR_CONTROL_FOUR
                     && wr_data[`MFS_CLR_BIT]) || (sleep_s && !sleep_d);
   end

   // ----------------------------------------------------------------------
   // Latched fault flags
   // ----------------------------------------------------------------------
   // A flag set in the clear cycle survives; conditions still present
   // simply hold their flag through the clear.
   genvar gc;
   generate
      for (gc = 0; gc < `MFS_NCOND; gc++)
      begin : g_latch
         always_ff @(posedge clock or negedge arst_n)
         begin
            if (!arst_n)
               latched[gc] <= 1'b0;
            else if (cond_s[gc])
               latched[gc] <= 1'b1;
            else if (clr_cmd)
               latched[gc] <= 1'b0;
         end
      end
   endgenerate

   assign {oc_lat, olb_lat, ola_lat, ots_lat, otw_lat, utw_lat, lrn_lat,
           stl_lat, pump_undervolt_flag_lat, supply_undervolt_flag_lat} = latched;

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         spi_err <= 1'b0;
      else if (lnk.proto_err)
         spi_err <= 1'b1;
      else if (clr_cmd)
         spi_err <= 1'b0;
   end

   // ----------------------------------------------------------------------
   // Fault pin
   // ----------------------------------------------------------------------
   // pull fault pin low on error
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         fault_drive <= 1'b0;
      else
         fault_drive <= spi_err || supply_undervolt_flag_lat || pump_undervolt_flag_lat || (|oc_lat)
                        || stl_lat || ots_lat || ola_lat || olb_lat;
   end

   assign fault_out_n_o  = 1'b0;
   assign fault_out_n_oe = fault_drive;

   // ----------------------------------------------------------------------
   // Status registers
   // ----------------------------------------------------------------------
   // summary bit reads the pin itself
   assign fault_summary = {~pin_s, spi_err, supply_undervolt_flag_lat, pump_undervolt_flag_lat, |oc_lat,
                           stl_lat, utw_lat | otw_lat | ots_lat,
                           ola_lat | olb_lat};
   assign overcurrent_detail = oc_lat;
   assign thermal_stall_openload_detail = {utw_lat, otw_lat, ots_lat,
                                           lrn_lat, stl_lat, 1'b0,
                                           olb_lat, ola_lat};

   // Unlisted addresses read zero
   always_comb
   begin
      next_rdata = `MFS_STATUS_RESET;
      case (lnk.addr)
         `MFS_ADDR_FAULT: next_rdata = fault_summary;
         `MFS_ADDR_DIAG1: next_rdata = overcurrent_detail;
         `MFS_ADDR_DIAG2: next_rdata = thermal_stall_openload_detail;
         default:
            if (lnk.addr >= `MFS_ADDR_CTRL_FIRST
                && lnk.addr <= `MFS_ADDR_CTRL_LAST)
               next_rdata = ctrl[3'(lnk.addr - `MFS_ADDR_CTRL_FIRST)];
      endcase
   end

   assign lnk.rdata  = next_rdata;
   assign lnk.status = fault_summary;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   property p_fault_bit;
      fault_summary[7] == !$past(fault_out_n_i, 2);
   endproperty
   a_fault_bit: assert property (p_fault_bit)
      else $error("fault bit does not mirror pin");
   property p_err_set;
      lnk.proto_err |=> spi_err;
   endproperty
   a_err_set: assert property (p_err_set)
      else $error("protocol error not latched");
   property p_err_pin;
      spi_err |=> fault_out_n_oe;
   endproperty
   a_err_pin: assert property (p_err_pin)
      else $error("fault pin not driven on error");
   property p_err_hold;
      (spi_err && !clr_cmd) |=> spi_err;
   endproperty
   a_err_hold: assert property (p_err_hold)
      else $error("error cleared without command");
   property p_supply_undervolt_flag;
      $past(supply_undervolt_flag, 3) |-> fault_summary[5];
   endproperty
   a_supply_undervolt_flag: assert property (p_supply_undervolt_flag)
      else $error("undervoltage not reported");
   property p_overcurrent;
      $past(oc_low2_bridge_b, 3) |-> overcurrent_detail[7]
                                     && fault_summary[3];
   endproperty
   a_overcurrent: assert property (p_overcurrent)
      else $error("overcurrent not reported");
   property p_temp;
      $past(over_temp_warning, 3) |-> fault_summary[1]
                                      && thermal_stall_openload_detail[6];
   endproperty
   a_temp: assert property (p_temp)
      else $error("temperature flag missing");
   property p_learn;
      $past(stall_learn_done, 3) |-> thermal_stall_openload_detail[4]
                                     && !thermal_stall_openload_detail[2];
   endproperty
   a_learn: assert property (p_learn)
      else $error("learn flag missing");
   property p_open_load;
      $past(open_load_bridge_b, 3) |-> thermal_stall_openload_detail[1]
                                       && fault_summary[0];
   endproperty
   a_open_load: assert property (p_open_load)
      else $error("open load not reported");
   property p_ctrl_write;
      (wr_ctrl && wr_addr == `MFS_ADDR_CTRL_LAST) |=>
         torque_count_ctl == $past(wr_data);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write)
      else $error("control write lost");
   c_frame: cover property (lnk.frame_done);
   c_error: cover property (lnk.proto_err ##[1:20] spi_err);
   c_clear: cover property (spi_err ##1 clr_cmd ##1 !spi_err);
   c_write: cover property (wr_ctrl);
endmodule

//--- test/mfs_spi_host.sv
// Serial host model that runs one frame at a time toward the status bank
`timescale 1ns/10ps
module mfs_spi_host
   import mfs_pkg::*;
(
   // Clock
   input  wire logic clock,
   // Serial pins
   output logic      chip_select_n,
   output logic      serial_clk,
   output logic      serial_in,
   input  wire logic serial_out,
   // Frame result
   output mfs_frame_t reply,
   output logic      done
);
   initial
   begin
      chip_select_n = 1'b1;
      serial_clk = 1'b0;
      serial_in = 1'b0;
      reply = '0;
      done = 1'b0;
   end

   // Edges above 16 or a long half period make faulty frames on purpose
   task automatic frame(input mfs_frame_t word, input int edges,
                        input int half);
      int i;
      @(negedge clock);
      chip_select_n = 1'b0;
      for (i = 0; i < edges; i++)
      begin
         serial_in = word[15 - (i % 16)];
         repeat (half) @(negedge clock);
         if (i < 16)
            reply[15 - i] = serial_out;
         serial_clk = 1'b1;
         repeat (half) @(negedge clock);
         serial_clk = 1'b0;
      end
      repeat (half) @(negedge clock);
      chip_select_n = 1'b1;
      // Released data line shows the inverse, not a stale bit
      serial_in = ~serial_in;
      done = 1'b1;
      @(negedge clock);
      done = 1'b0;
      repeat (4) @(negedge clock);
   endtask
endmodule

//--- test/test_mfs_status_regs.sv
// Self-checking bench for the fault status bank
`timescale 1ns/10ps
module test_mfs_status_regs;
   import mfs_pkg::*;
   logic       clock, arst_n, sleep_in_n, ext_pull, perr, done;
   logic       chip_select_n, serial_clk, serial_in, serial_out;
   logic       serial_out_oe, fault_wire, fault_out_n_o, fault_out_n_oe;
   mfs_cond_t  cond, s;
   mfs_frame_t reply;
   mfs_byte_t  ctl [7];
   mfs_byte_t  cexp [7];
   mfs_byte_t  exp_q [$];
   mfs_byte_t  d;
   int         bad_count, checked, seed, half, a, n;

   // Open-drain wire with pull-up; ext_pull is another device
   assign fault_wire = (fault_out_n_oe ? fault_out_n_o : 1'b1) & ~ext_pull;
   always #2.5 clock = ~clock;

   mfs_status_regs DUT (
      .clock(clock), .arst_n(arst_n), .chip_select_n(chip_select_n),
      .serial_clk(serial_clk), .serial_in(serial_in),
      .serial_out(serial_out), .serial_out_oe(serial_out_oe),
      .sleep_in_n(sleep_in_n), .fault_out_n_i(fault_wire),
      .fault_out_n_o(fault_out_n_o), .fault_out_n_oe(fault_out_n_oe),
      .supply_undervolt_flag(cond[0]), .pump_undervolt_flag(cond[1]),
      .stall_summary_flag(cond[2]), .stall_learn_done(cond[3]),
      .under_temp_warning(cond[4]), .over_temp_warning(cond[5]),
      .over_temp_shutdown(cond[6]), .open_load_bridge_a(cond[7]),
      .open_load_bridge_b(cond[8]), .oc_high1_bridge_a(cond[9]),
      .oc_low1_bridge_a(cond[10]), .oc_high2_bridge_a(cond[11]),
      .oc_low2_bridge_a(cond[12]), .oc_high1_bridge_b(cond[13]),
      .oc_low1_bridge_b(cond[14]), .oc_high2_bridge_b(cond[15]),
      .oc_low2_bridge_b(cond[16]), .control_one(ctl[0]),
      .control_two(ctl[1]), .control_three(ctl[2]),
      .control_four(ctl[3]), .control_five(ctl[4]),
      .stall_threshold_ctl(ctl[5]), .torque_count_ctl(ctl[6]));

   mfs_spi_host host (
      .clock(clock), .chip_select_n(chip_select_n),
      .serial_clk(serial_clk), .serial_in(serial_in),
      .serial_out(serial_out), .reply(reply), .done(done));

   // Warnings and learn done do not pull the pin
   function automatic logic pin_exp();
      return perr | (|s[2:0]) | (|s[16:6]);
   endfunction

   function automatic mfs_byte_t exp_reg(input int r);
      case (r)
         0: exp_reg = {pin_exp() | ext_pull, perr, s[0], s[1], |s[16:9],
                       s[2], |s[6:4], |s[8:7]};
         1: exp_reg = s[16:9];
         2: exp_reg = {s[4], s[5], s[6], s[3], s[2], 1'b0, s[8], s[7]};
         default: exp_reg = (r >= 3 && r <= 9) ? cexp[r - 3] : 8'h00;
      endcase
   endfunction

   task automatic cmp_byte(input mfs_byte_t got, input mfs_byte_t want);
      checked++;
      if (got !== want)
      begin
         bad_count++;
         $display("unexpected at %0t: byte %h not %h", $time, got, want);
      end
   endtask

   task automatic cmp_bit(input logic got, input logic want);
      checked++;
      if (got !== want)
      begin
         bad_count++;
         $display("unexpected at %0t: pin %b not %b", $time, got, want);
      end
   endtask

   task automatic wr(input int r, input mfs_byte_t v);
      half = 6 + 3 * ($random(seed) & 1);
      host.frame({2'b00, r[4:0], 1'b0, v}, 16, half);
   endtask

   task automatic rd(input int r);
      exp_q.push_back(exp_reg(r));
      host.frame({2'b01, r[4:0], 1'b0, 8'h00}, 16, 6);
   endtask

   // Present conditions survive a clear
   task automatic clr(input int how);
      if (how)
      begin
         sleep_in_n = 1'b0;
         repeat (3) @(negedge clock);
         sleep_in_n = 1'b1;
      end
      else
         wr(6, {1'b1, cexp[3][6:0]});
      repeat (4) @(negedge clock);
      s = cond;
      perr = 1'b0;
   endtask

   task automatic give_verdict;
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0 && exp_q.size() == 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Reply comparator
   always @(posedge clock)
      if (done && exp_q.size() > 0)
         cmp_byte(reply[7:0], exp_q.pop_front());

   initial
   begin
      repeat (90000) @(posedge clock);
      bad_count++;
      give_verdict;
   end

   initial
   begin
      clock = 1'b0;
      arst_n = 1'b0;
      sleep_in_n = 1'b1;
      ext_pull = 1'b0;
      cond = '0;
      s = '0;
      perr = 1'b0;
      seed = 32'hd3aba713;
      cexp = '{8'h00, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      repeat (6) @(negedge clock);
      arst_n = 1'b1;
      repeat (4) @(negedge clock);
      cmp_bit(serial_out_oe, 1'b0);
      for (a = 0; a < 11; a++)
         rd(a);
      for (a = 0; a < 10; a++)
      begin
         d = mfs_byte_t'($random(seed));
         wr(a, d);
         if (a >= 3)
            cexp[a - 3] = (a == 6) ? {1'b0, d[6:0]} : d;
         rd(a);
         if (a >= 3)
            cmp_byte(ctl[a - 3], cexp[a - 3]);
      end
      for (n = 0; n < 16; n++)
      begin
         @(negedge clock);
         cond = mfs_cond_t'($random(seed)) & (n < 3 ? 17'h00038 : 17'h1ffff);
         s = s | cond;
         repeat (3) @(negedge clock);
         cond = '0;
         ext_pull = (n % 3 == 0);
         repeat (8) @(negedge clock);
         cmp_bit(fault_out_n_oe, pin_exp());
         rd(0);
         rd(1);
         rd(2);
         ext_pull = 1'b0;
         clr(n % 2);
         rd(0);
      end
      host.frame(16'h4000, 17, 6);
      perr = 1'b1;
      cond[0] = 1'b1;
      s[0] = 1'b1;
      repeat (6) @(negedge clock);
      cmp_bit(fault_out_n_oe, 1'b1);
      rd(0);
      clr(1);
      rd(0);
      cond = '0;
      clr(0);
      rd(0);
      host.frame(16'h0000, 0, 2100);
      perr = 1'b1;
      rd(0);
      clr(0);
      rd(0);
      repeat (10) @(negedge clock);
      give_verdict;
   end
endmodule
